// [sas_afe_model.sv]
// analog front end model: channel levels, sample-and-hold and comparator
`timescale 1ns/1ps
module sas_afe_model (
    input wire logic clock, // converter clock
    input wire sas_pkg::sas_afe_t afe, // front end controls from the sequencer
    input wire logic [11:0] level [16], // channel levels in quarter-code steps
    output logic compHigh // held input above trial voltage
);
    logic [11:0] held_r;
    ////////////////////////////////////////////////////////////////////////////////
    // track then hold
    always_ff @(posedge clock) begin
        if (afe.sampleEn) begin
            held_r <= level[afe.channel];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // comparator decision; held input must be strictly above four times the trial code, so an exact multiple reads one code low
    assign compHigh = held_r > {afe.dacCode, 2'b00};
endmodule : sas_afe_model

// [sas_pkg.sv]
// constants, register map and field layouts for the SAR converter sequencer
package sas_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    localparam logic [7:0] START_OFS = 8'h0C;
    // status field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_FLAG = 1;
    localparam int STAT_PAUSE = 2;
    localparam int STAT_SENSE = 3;
    localparam int STAT_CH_LSB = 8;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    localparam logic [9:0] CONV_RST = 10'h000;
    // default timing in clock cycles and result widths in bits
    localparam int SAMPLE_CYC_DEF = 4;
    localparam int COMPARE_CYC_DEF = 3;
    localparam int RES_HI_BITS = 10;
    localparam int RES_LO_BITS = 8;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_CONT = 2'h1,
        MODE_STOP = 2'h2,
        MODE_SENSE = 2'h3
    } sas_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SAMPLE = 5'b00010,
        ST_TRIAL = 5'b00100,
        ST_FINISH = 5'b01000,
        ST_PAUSE = 5'b10000
    } sas_state_t;

    // control register layout
    typedef struct packed {
        logic [15:0] spare;
        logic [3:0] lastChannelSelect;
        logic [3:0] firstChannelSelect;
        logic [2:0] spare2;
        logic triggerSourceSelectHi;
        logic triggerSourceSelectLo;
        logic res10;
        sas_mode_t mode;
    } sas_ctrl_t;

    // analog front end controls
    typedef struct packed {
        logic sampleEn;
        logic [3:0] channel;
        logic [9:0] dacCode;
    } sas_afe_t;
endpackage : sas_pkg

// [sas_top.sv]
// successive approximation converter sequencer with an AXI4-Lite register slave
//
// Operation
// - an n-bit result takes exactly n comparator trials, starting at half range.
// - the selected input is sampled and held before the trials start.
// - the trial voltage comes from the data register and the comparator judges it.
// - one result register exists and every finished conversion overwrites it.
// - each finished conversion sets the completion flag.
// - single mode converts first through last channel once and stops.
// - continuous mode wraps over the channel range until busy is cleared.
// - convert-and-stop mode pauses after every channel.
// - a pause ends only when the selected activation source fires or busy is cleared.
// - sense mode compares the input against the data register without converting.
// - at 10 bits the code is the input scaled by 1024 over the reference.
// - at 8 bits the code is the input scaled by 256 over the reference.
// - the result holds until the next sampling ends; only after a stop or a pause does that wait for an activation.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sas_top #(
    parameter int NUM_CH = 8,
    parameter int SAMPLE_CYC = sas_pkg::SAMPLE_CYC_DEF,
    parameter int COMPARE_CYC = sas_pkg::COMPARE_CYC_DEF
) (
    input wire logic clock, // 100 MHz
    input wire logic reset_n, // async reset
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic hwTrigger, // hardware activation pulse
    input wire logic compHigh, // held input above dac voltage
    output sas_pkg::sas_afe_t afe // analog front end controls
);

    generate
        if (NUM_CH < 2 || NUM_CH > 16 || SAMPLE_CYC < 2 || SAMPLE_CYC > 255
                || COMPARE_CYC < 2 || COMPARE_CYC > 255) begin : g_bad
            $error("sas_top: parameter out of range");
        end
    endgenerate

    localparam logic [7:0] SAMPLE_LD = 8'(SAMPLE_CYC - 1);
    localparam logic [7:0] COMPARE_LD = 8'(COMPARE_CYC - 1);

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
            input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    function automatic logic [9:0] dacOf(input logic [9:0] code, input logic res10);
        return res10 ? code : {code[7:0], 2'b00};
    endfunction : dacOf

    sas_pkg::sas_ctrl_t ctrl_r;
    sas_pkg::sas_state_t state_r;
    logic [3:0] chan_r;
    logic [3:0] bitIdx_r;
    logic [7:0] waitCnt_r;
    logic [9:0] convReg_r;
    logic busy_r;
    logic flag_r;
    logic senseHigh_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    sas_pkg::sas_afe_t afe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic wrTake;
    logic [7:0] wrAddr;
    logic wrMapped;
    logic rdTake;
    logic swStart;
    logic clrBusy;
    logic clrFlag;
    logic dataWr;
    logic fire;
    logic [3:0] topBit;

    assign wrTake = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
    assign wrAddr = s_axi_awaddr;
    assign wrMapped = wrAddr[1:0] == 2'h0 && wrAddr <= sas_pkg::START_OFS;
    assign rdTake = s_axi_arvalid && !arready_r && !rvalid_r;
    assign swStart = wrTake && wrAddr == sas_pkg::START_OFS && s_axi_wstrb[0] && s_axi_wdata[0];
    assign clrBusy = wrTake && wrAddr == sas_pkg::STAT_OFS && s_axi_wstrb[0]
        && !s_axi_wdata[sas_pkg::STAT_BUSY];
    assign clrFlag = wrTake && wrAddr == sas_pkg::STAT_OFS && s_axi_wstrb[0]
        && s_axi_wdata[sas_pkg::STAT_FLAG];
    // data register only accepts writes while the sequencer is idle
    assign dataWr = wrTake && wrAddr == sas_pkg::DATA_OFS && !busy_r;
    assign topBit = ctrl_r.res10 ? 4'(sas_pkg::RES_HI_BITS - 1) : 4'(sas_pkg::RES_LO_BITS - 1);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= sas_pkg::RESP_OKAY;
        end else begin
            awready_r <= wrTake;
            wready_r <= wrTake;
            if (wrTake) begin
                bresp_r <= wrMapped ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
            end
            // response only after the address and data handshakes
            if (awready_r) begin
                bvalid_r <= 1'b1;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= sas_pkg::CTRL_RST;
        end else if (wrTake && wrAddr == sas_pkg::CTRL_OFS) begin
            ctrl_r <= mergeBytes(ctrl_r, s_axi_wdata, s_axi_wstrb);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= sas_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            arready_r <= rdTake;
            if (rdTake) begin
                rresp_r <= sas_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    sas_pkg::CTRL_OFS: rdata_r <= ctrl_r;
                    sas_pkg::STAT_OFS: rdata_r <= {20'h00000, chan_r, 4'h0, senseHigh_r,
                        state_r == sas_pkg::ST_PAUSE, flag_r, busy_r};
                    sas_pkg::DATA_OFS: rdata_r <= {22'h000000, convReg_r};
                    sas_pkg::START_OFS: rdata_r <= 32'h0000_0000;
                    default: begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= sas_pkg::RESP_SLVERR;
                    end
                endcase
            end
            // read data only after the address handshake
            if (arready_r) begin
                rvalid_r <= 1'b1;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        unique case ({ctrl_r.triggerSourceSelectHi, ctrl_r.triggerSourceSelectLo})
            2'b00: fire = swStart;
            2'b01: fire = hwTrigger;
            default: fire = swStart || hwTrigger;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= sas_pkg::ST_IDLE;
            busy_r <= 1'b0;
            chan_r <= 4'h0;
            waitCnt_r <= 8'h00;
        end else if (clrBusy) begin
            state_r <= sas_pkg::ST_IDLE;
            busy_r <= 1'b0;
        end else begin
            unique case (state_r)
                sas_pkg::ST_IDLE: begin
                    if (fire) begin
                        state_r <= sas_pkg::ST_SAMPLE;
                        busy_r <= 1'b1;
                        chan_r <= ctrl_r.firstChannelSelect;
                        waitCnt_r <= SAMPLE_LD;
                    end
                end
                sas_pkg::ST_SAMPLE: begin
                    if (waitCnt_r == 8'h00) begin
                        state_r <= sas_pkg::ST_TRIAL;
                        waitCnt_r <= COMPARE_LD;
                    end else begin
                        waitCnt_r <= waitCnt_r - 8'h01;
                    end
                end
                sas_pkg::ST_TRIAL: begin
                    if (waitCnt_r != 8'h00) begin
                        waitCnt_r <= waitCnt_r - 8'h01;
                    end else if (ctrl_r.mode == sas_pkg::MODE_SENSE || bitIdx_r == 4'h0) begin
                        state_r <= sas_pkg::ST_FINISH;
                    end else begin
                        waitCnt_r <= COMPARE_LD;
                    end
                end
                sas_pkg::ST_FINISH: begin
                    waitCnt_r <= SAMPLE_LD;
                    if (chan_r == ctrl_r.lastChannelSelect) begin
                        chan_r <= ctrl_r.firstChannelSelect;
                    end else begin
                        chan_r <= chan_r + 4'h1;
                    end
                    unique case (ctrl_r.mode)
                        sas_pkg::MODE_SINGLE: begin
                            if (chan_r == ctrl_r.lastChannelSelect) begin
                                state_r <= sas_pkg::ST_IDLE;
                                busy_r <= 1'b0;
                            end else begin
                                state_r <= sas_pkg::ST_SAMPLE;
                            end
                        end
                        sas_pkg::MODE_CONT: state_r <= sas_pkg::ST_SAMPLE;
                        sas_pkg::MODE_STOP: state_r <= sas_pkg::ST_PAUSE;
                        sas_pkg::MODE_SENSE: begin
                            state_r <= sas_pkg::ST_IDLE;
                            busy_r <= 1'b0;
                        end
                    endcase
                end
                sas_pkg::ST_PAUSE: begin
                    if (fire) begin
                        state_r <= sas_pkg::ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    // successive approximation register, also the single result register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            convReg_r <= sas_pkg::CONV_RST;
            bitIdx_r <= 4'h0;
        end else if (dataWr) begin
            convReg_r <= 10'(mergeBytes({22'h000000, convReg_r}, s_axi_wdata, s_axi_wstrb));
        end else if (ctrl_r.mode != sas_pkg::MODE_SENSE && !clrBusy) begin
            if (state_r == sas_pkg::ST_SAMPLE && waitCnt_r == 8'h00) begin
                convReg_r <= 10'h001 << topBit;
                bitIdx_r <= topBit;
            end else if (state_r == sas_pkg::ST_TRIAL && waitCnt_r == 8'h00) begin
                convReg_r[bitIdx_r] <= compHigh;
                if (bitIdx_r != 4'h0) begin
                    convReg_r[bitIdx_r - 4'h1] <= 1'b1;
                    bitIdx_r <= bitIdx_r - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            senseHigh_r <= 1'b0;
        end else if (ctrl_r.mode == sas_pkg::MODE_SENSE && state_r == sas_pkg::ST_TRIAL
                && waitCnt_r == 8'h00) begin
            senseHigh_r <= compHigh;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else if (state_r == sas_pkg::ST_FINISH) begin
            flag_r <= 1'b1;
        end else if (clrFlag) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            afe_r <= '0;
        end else begin
            afe_r.sampleEn <= state_r == sas_pkg::ST_SAMPLE;
            afe_r.channel <= chan_r;
            afe_r.dacCode <= dacOf(convReg_r, ctrl_r.res10);
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign afe = afe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic [4:0] trialCnt_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            trialCnt_r <= 5'h00;
        end else if (state_r == sas_pkg::ST_SAMPLE) begin
            trialCnt_r <= 5'h00;
        end else if (state_r == sas_pkg::ST_TRIAL && waitCnt_r == 8'h00) begin
            trialCnt_r <= trialCnt_r + 5'h01;
        end
    end

    trial_count_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_FINISH && ctrl_r.mode != sas_pkg::MODE_SENSE
        |-> trialCnt_r == (ctrl_r.res10 ? 5'h0A : 5'h08))
        else $error("wrong number of trials");

    half_range_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_TRIAL && $past(state_r) == sas_pkg::ST_SAMPLE
        && ctrl_r.mode != sas_pkg::MODE_SENSE && !$past(clrBusy)
        |-> convReg_r == (10'h001 << topBit))
        else $error("first trial not at half range");

    sample_first_a: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state_r == sas_pkg::ST_TRIAL) |-> $past(state_r) == sas_pkg::ST_SAMPLE
        && $past(afe_r.sampleEn))
        else $error("trial without sampling");

    dac_settled_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_TRIAL && waitCnt_r == 8'h00
        |-> afe_r.dacCode == dacOf(convReg_r, ctrl_r.res10))
        else $error("dac not settled at decision");

    flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_FINISH |=> flag_r)
        else $error("flag not set on completion");

    single_stop_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_FINISH && ctrl_r.mode == sas_pkg::MODE_SINGLE && !clrBusy
        && chan_r == ctrl_r.lastChannelSelect |=> state_r == sas_pkg::ST_IDLE && !busy_r)
        else $error("single mode did not stop");

    cont_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_FINISH && ctrl_r.mode == sas_pkg::MODE_CONT && !clrBusy
        && chan_r == ctrl_r.lastChannelSelect
        |=> state_r == sas_pkg::ST_SAMPLE && chan_r == $past(ctrl_r.firstChannelSelect))
        else $error("continuous mode did not wrap");

    stop_pause_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_FINISH && ctrl_r.mode == sas_pkg::MODE_STOP && !clrBusy
        |=> state_r == sas_pkg::ST_PAUSE)
        else $error("convert-and-stop did not pause");

    pause_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_PAUSE && !fire && !clrBusy |=> state_r == sas_pkg::ST_PAUSE)
        else $error("pause left without activation");

    sense_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_TRIAL && ctrl_r.mode == sas_pkg::MODE_SENSE
        |=> $stable(convReg_r))
        else $error("sense mode altered data register");

    result_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_r == sas_pkg::ST_IDLE && !dataWr |=> $stable(convReg_r))
        else $error("result changed while idle");

endmodule : sas_top

// [sas_top_bench.sv]
// self-checking bench for the converter sequencer over its register bus
`timescale 1ns/1ps
module sas_top_bench;
    logic clock;
    logic reset_n;
    logic [7:0] awAddr, arAddr;
    logic [31:0] wData, rData, rd;
    logic [3:0] wStrb;
    logic awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady;
    logic [1:0] bResp, rResp, rsp;
    logic hwTrigger, compHigh;
    sas_pkg::sas_afe_t afe;
    logic [11:0] level [16];
    int n_errors;
    int check_count;

    // long sampling leaves software time to fetch each result before the next trial
    sas_top #(.SAMPLE_CYC(16)) DUT (
        .clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .hwTrigger(hwTrigger), .compHigh(compHigh), .afe(afe)
    );

    sas_afe_model AFE (.clock(clock), .afe(afe), .level(level), .compHigh(compHigh));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // valids drop at the edge their ready is seen; ready held until the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            awValid <= awValid & ~awReady;
            wValid <= wValid & ~wReady;
        end while (bValid !== 1'b1 && n < 200);
        rsp = bResp;
        bReady <= 1'b0;
        chk(32'(n < 200), 32'h1);
    endtask : axw

    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge clock);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            arValid <= arValid & ~arReady;
        end while (rValid !== 1'b1 && n < 200);
        rd = rData;
        rsp = rResp;
        rReady <= 1'b0;
        chk(32'(n < 200), 32'h1);
    endtask : axr

    // polls status until the completion flag; rd keeps that status word
    task automatic wait_flag();
        int n;
        n = 0;
        do begin
            axr(sas_pkg::STAT_OFS);
            n++;
        end while (rd[sas_pkg::STAT_FLAG] !== 1'b1 && n < 100);
        chk(32'(n < 100), 32'h1);
    endtask : wait_flag

    // result read straight after the flag, then the flag is cleared keeping busy
    task automatic wait_conv(input logic [9:0] code);
        wait_flag();
        axr(sas_pkg::DATA_OFS);
        chk(rd, 32'(code));
        axw(sas_pkg::STAT_OFS, 32'h3);
    endtask : wait_conv

    task automatic hw_pulse();
        hwTrigger <= 1'b1;
        @(posedge clock);
        hwTrigger <= 1'b0;
    endtask : hw_pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        {awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady} = '0;
        wStrb = 4'hF;
        hwTrigger = 1'b0;
        n_errors = 0;
        check_count = 0;
        for (int i = 0; i < 16; i++) begin
            level[i] = 12'h000;
        end
        level[0] = 12'h7F5;
        level[1] = 12'hFFE;
        level[2] = 12'h001;
        level[3] = 12'h556;
        level[4] = 12'h803;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;

        axr(sas_pkg::CTRL_OFS);
        chk(rd, sas_pkg::CTRL_RST);
        axr(sas_pkg::STAT_OFS);
        chk(rd, 32'h0);
        axr(8'h10);
        chk({rd[29:0], rsp}, {30'h0, sas_pkg::RESP_SLVERR});
        axw(8'h10, 32'h0);
        chk(32'(rsp), 32'(sas_pkg::RESP_SLVERR));
        $display("test registers done");

        axw(sas_pkg::CTRL_OFS, 32'h0000_3104);
        axw(sas_pkg::START_OFS, 32'h1);
        wait_conv(10'h3FF);
        wait_conv(10'h000);
        wait_conv(10'h155);
        repeat (60) @(posedge clock);
        axr(sas_pkg::STAT_OFS);
        chk(32'(rd[1:0]), 32'h0);
        $display("test single mode done");

        axw(sas_pkg::CTRL_OFS, 32'h0000_0000);
        axw(sas_pkg::START_OFS, 32'h1);
        repeat (24) @(posedge clock);
        level[0] <= 12'h100;
        wait_conv(10'h07F);
        level[0] <= 12'h7F5;
        $display("test hold and 8 bit done");

        axw(sas_pkg::CTRL_OFS, 32'h0000_3205);
        axw(sas_pkg::START_OFS, 32'h1);
        wait_conv(10'h000);
        wait_conv(10'h155);
        wait_conv(10'h000);
        axw(sas_pkg::STAT_OFS, 32'h0);
        axr(sas_pkg::STAT_OFS);
        chk(32'(rd[0]), 32'h0);
        $display("test continuous mode done");

        axw(sas_pkg::CTRL_OFS, 32'h0000_100E);
        hw_pulse();
        wait_conv(10'h1FD);
        axr(sas_pkg::STAT_OFS);
        chk(32'(rd[2:0]), 32'h5);
        axw(sas_pkg::START_OFS, 32'h1);
        repeat (60) @(posedge clock);
        axr(sas_pkg::STAT_OFS);
        chk(32'(rd[2:0]), 32'h5);
        hw_pulse();
        wait_conv(10'h3FF);
        axw(sas_pkg::STAT_OFS, 32'h0);
        $display("test convert and stop done");

        axw(sas_pkg::DATA_OFS, 32'h200);
        axw(sas_pkg::CTRL_OFS, 32'h0000_4417);
        axw(sas_pkg::START_OFS, 32'h1);
        wait_flag();
        chk(32'(rd[sas_pkg::STAT_SENSE]), 32'h1);
        axw(sas_pkg::STAT_OFS, 32'h3);
        axw(sas_pkg::DATA_OFS, 32'h201);
        hw_pulse();
        wait_flag();
        chk(32'(rd[sas_pkg::STAT_SENSE]), 32'h0);
        $display("test sense mode done");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end
endmodule : sas_top_bench
